/* pmg_guard.sv */
// Overview of operation
// - Guard code 11 protects nothing.
// - 4 kW, code 10: 0000h-01FFh locked.
// - 4 kW, code 01: 0000h-07FFh locked.
// - 4 kW, code 00: whole array locked.
// - 8 kW, code 10: 0000h-01FFh locked.
// - 8 kW, code 01: 0000h-0FFFh locked.
// - 8 kW, code 00: whole array locked.
// - Lock low: programmer writes refused, reads zero.
// - CPU reads never blocked.
// - Self-writes ignore the read lock.
// - Four user ID words read/write.
// - Part code word at 8006h.
// - Revision code word at 8005h.
// - ID words are read-only, never erased.
// - Programmer can read both ID words.
// - Lock bit 1 off, 0 on.
// - Unlocking erase wipes all; bulk wipes config and array.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pmg_guard
   import pmg_pkg::*;
#(
   parameter int MEM_KW = 4,
   parameter logic [13:0] PART_CODE = 14'h0123, // Arbitrary value
   parameter logic [13:0] REV_CODE = 14'h0001   // Arbitrary value
) (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   // Avalon-MM slave
   input  wire logic [PMG_AW-1:0]     avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [PMG_BUS_DW-1:0] avs_writedata,
   output logic [PMG_BUS_DW-1:0]      avs_readdata,
   output logic                       avs_waitrequest,
   // CPU port
   input  wire logic                  cpu_rd_req,
   input  wire logic                  cpu_wr_req,
   input  wire logic [PMG_PM_AW-1:0]  cpu_addr,
   input  wire logic [PMG_DW-1:0]     cpu_wdata,
   output logic [PMG_DW-1:0]          cpu_rd_data,
   output logic                       cpu_rd_valid,
   output logic                       cpu_wr_blocked,
   // Programmer port
   input  wire logic                  prg_rd_req,
   input  wire logic                  prg_wr_req,
   input  wire logic                  prg_erase_req,
   input  wire logic                  prg_bulk_req,
   input  wire logic [PMG_AW-1:0]     prg_addr,
   input  wire logic [PMG_DW-1:0]     prg_wdata,
   output logic                       prg_waitreq,
   output logic [PMG_DW-1:0]          prg_rd_data,
   output logic                       prg_rd_valid,
   output logic                       prg_refused,
   // Program memory array
   output logic [PMG_PM_AW-1:0]       mem_addr,
   output logic [PMG_DW-1:0]          mem_wdata,
   output logic                       mem_we,
   output logic                       mem_re,
   output logic                       mem_erase_row,
   output logic                       mem_erase_all,
   input  wire logic [PMG_DW-1:0]     mem_rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   pmg_bus_state_type  bus_state;
   logic [1:0]         guard;
   logic               read_lock_n;
   logic [PMG_DW-1:0]  user_id [PMG_UID_NUM];
   logic [1:0]         stat;
   logic [PMG_PM_AW-1:0] cpu_pm_addr;
   logic [PMG_PM_AW-1:0] prg_pm_addr;
   logic               cpu_blocked;
   logic               cpu_busy;
   logic               prg_go;
   logic               prg_cfg;
   logic               bus_wr;
   logic               bus_take;
   logic               cpu_wr_ok;
   logic               prg_wr_pm;
   logic               prg_wr_deny;
   logic               unlock_erase;
   logic               cfg_wipe;
   logic [1:0]         s1_own;
   logic [1:0]         s2_own;
   logic               s1_zero;
   logic               s2_zero;
   logic               s1_cfg;
   logic               s2_cfg;
   logic [PMG_DW-1:0]  s1_data;
   logic [PMG_DW-1:0]  s2_data;
   logic [PMG_DW-1:0]  next_rd;

   // Word seen at a configuration-space index, shared by bus and programmer
   function automatic logic [PMG_DW-1:0] id_word(input logic [15:0] a);
      logic [PMG_DW-1:0] w;
      w = '0;
      if (a >= PMG_UID_BASE && a < PMG_UID_BASE + 16'h0004) begin
         w = user_id[a[1:0]];
      end else if (a == PMG_REV_OFS) begin
         w = REV_CODE;
      end else if (a == PMG_PART_OFS) begin
         w = PART_CODE;
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Address checks
   pmg_region_check #(.MEM_KW(MEM_KW)) u_cpu_check (
      .guard    (guard),
      .addr_in  (cpu_addr),
      .addr_out (cpu_pm_addr),
      .blocked  (cpu_blocked)
   );

   assign prg_pm_addr = prg_addr[PMG_PM_AW-1:0] & (MEM_KW == 8 ? 13'h1fff : 13'h0fff);

   ////////////////////////////////////////////////////////////////////////////
   // Request decode; the CPU always wins the array
   assign cpu_busy = cpu_rd_req | cpu_wr_req;
   assign prg_waitreq = cpu_busy;
   assign prg_go = !cpu_busy;
   assign prg_cfg = prg_addr[PMG_CFG_SPACE_BIT];
   assign cpu_wr_ok = cpu_wr_req && !cpu_rd_req && !cpu_blocked;
   assign prg_wr_pm = prg_go && prg_wr_req && !prg_cfg;
   assign prg_wr_deny = prg_wr_pm && !read_lock_n;
   assign unlock_erase = prg_go && prg_erase_req && !read_lock_n;
   assign cfg_wipe = unlock_erase || (prg_go && prg_bulk_req);

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, then the access is taken
   assign avs_waitrequest = (avs_read | avs_write) && (bus_state != BUS_ACK);
   assign bus_take = bus_state == BUS_ACK;
   assign bus_wr = bus_take && avs_write;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bus_state <= BUS_IDLE;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state <= BUS_ACK;
               end
            end
            BUS_ACK: bus_state <= BUS_IDLE;
            default: bus_state <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         avs_readdata <= '0;
      end else if (bus_state == BUS_IDLE && avs_read) begin
         if (avs_address == PMG_CFG_OFS) begin
            avs_readdata <= {29'h0, read_lock_n, guard};
         end else if (avs_address == PMG_STAT_OFS) begin
            avs_readdata <= {30'h0, stat};
         end else begin
            avs_readdata <= {18'h0, id_word(avs_address)};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration word; unlocking and bulk erases return it to the blank state, row erases leave it
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         guard <= PMG_GUARD_RST;
         read_lock_n <= PMG_LOCK_N_RST;
      end else if (cfg_wipe) begin
         guard <= PMG_GUARD_RST;
         read_lock_n <= PMG_LOCK_N_RST;
      end else if (bus_wr && avs_address == PMG_CFG_OFS) begin
         guard <= avs_writedata[PMG_CFG_GUARD_LSB +: 2];
         read_lock_n <= avs_writedata[PMG_CFG_LOCK_BIT];
      end
   end

   // User ID words; part and revision have no storage, so no write reaches them
   genvar gi;
   generate
      for (gi = 0; gi < PMG_UID_NUM; gi++) begin : g_uid
         always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               user_id[gi] <= PMG_BLANK_WORD;
            end else if (cfg_wipe) begin
               user_id[gi] <= PMG_BLANK_WORD;
            end else if (bus_wr && avs_address == PMG_UID_BASE + 16'(gi)) begin
               user_id[gi] <= avs_writedata[PMG_DW-1:0];
            end else if (prg_go && prg_wr_req && read_lock_n
                         && prg_addr == PMG_UID_BASE + 16'(gi)) begin
               user_id[gi] <= prg_wdata;
            end
         end
      end
   endgenerate

   // Sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stat <= '0;
      end else begin
         if (cpu_wr_req && !cpu_rd_req && cpu_blocked) begin
            stat[PMG_STAT_SELF_BIT] <= 1'b1;
         end else if (bus_wr && avs_address == PMG_STAT_OFS
                      && avs_writedata[PMG_STAT_SELF_BIT]) begin
            stat[PMG_STAT_SELF_BIT] <= 1'b0;
         end
         if (prg_wr_deny) begin
            stat[PMG_STAT_EXT_BIT] <= 1'b1;
         end else if (bus_wr && avs_address == PMG_STAT_OFS
                      && avs_writedata[PMG_STAT_EXT_BIT]) begin
            stat[PMG_STAT_EXT_BIT] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Array commands
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_addr <= '0;
         mem_wdata <= '0;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         mem_erase_row <= 1'b0;
         mem_erase_all <= 1'b0;
         cpu_wr_blocked <= 1'b0;
         prg_refused <= 1'b0;
      end else begin
         mem_we <= cpu_wr_ok || (prg_wr_pm && read_lock_n);
         mem_re <= cpu_rd_req || (prg_go && prg_rd_req && !prg_cfg);
         mem_erase_row <= prg_go && prg_erase_req && read_lock_n && !prg_cfg;
         mem_erase_all <= cfg_wipe;
         cpu_wr_blocked <= cpu_wr_req && !cpu_rd_req && cpu_blocked;
         prg_refused <= prg_wr_deny;
         if (cpu_busy) begin
            mem_addr <= cpu_pm_addr;
            mem_wdata <= cpu_wdata;
         end else begin
            mem_addr <= prg_pm_addr;
            mem_wdata <= prg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read pipeline: issue, array cycle, answer
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s1_own <= '0;
         s2_own <= '0;
         s1_zero <= 1'b0;
         s2_zero <= 1'b0;
         s1_cfg <= 1'b0;
         s2_cfg <= 1'b0;
         s1_data <= '0;
         s2_data <= '0;
      end else begin
         s1_own <= {prg_go && prg_rd_req, cpu_rd_req};
         s1_zero <= !read_lock_n && !prg_cfg;
         s1_cfg <= prg_cfg;
         s1_data <= id_word(prg_addr);
         s2_own <= s1_own;
         s2_zero <= s1_zero;
         s2_cfg <= s1_cfg;
         s2_data <= s1_data;
      end
   end

   always_comb begin
      next_rd = mem_rdata;
      if (s2_cfg) begin
         next_rd = s2_data;
      end else if (s2_zero) begin
         next_rd = '0;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cpu_rd_data <= '0;
         cpu_rd_valid <= 1'b0;
         prg_rd_data <= '0;
         prg_rd_valid <= 1'b0;
      end else begin
         cpu_rd_valid <= s2_own[0];
         prg_rd_valid <= s2_own[1];
         if (s2_own[0]) begin
            cpu_rd_data <= mem_rdata;
         end
         if (s2_own[1]) begin
            prg_rd_data <= next_rd;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence seq_prg_locked_rd;
      prg_rd_req && prg_go && !prg_cfg && !read_lock_n;
   endsequence
   sequence seq_zero_answer;
      ##3 (prg_rd_valid && prg_rd_data == '0);
   endsequence

   AST_GUARD_OFF: assert property (@(posedge sys_clk) disable iff (reset)
      cpu_wr_req && !cpu_rd_req && guard == PMG_GUARD_OFF |=> mem_we)
      else $error("unguarded self-write dropped");
   AST_BOOT: assert property (@(posedge sys_clk) disable iff (reset)
      cpu_wr_req && !cpu_rd_req && guard == PMG_GUARD_BOOT
      |-> ##1 (mem_we == ($past(cpu_pm_addr) >= 13'h0200)))
      else $error("boot region check wrong");
   AST_HALF: assert property (@(posedge sys_clk) disable iff (reset)
      cpu_wr_req && !cpu_rd_req && guard == PMG_GUARD_HALF
      |=> cpu_wr_blocked == ($past(cpu_pm_addr) < (MEM_KW == 8 ? 13'h1000 : 13'h0800)))
      else $error("half region check wrong");
   AST_ALL: assert property (@(posedge sys_clk) disable iff (reset)
      cpu_wr_req && !cpu_rd_req && guard == PMG_GUARD_ALL |=> cpu_wr_blocked && !mem_we)
      else $error("full guard let a write through");
   AST_LOCK_WR: assert property (@(posedge sys_clk) disable iff (reset)
      prg_wr_pm && !read_lock_n |=> prg_refused && !mem_we)
      else $error("locked programmer write not refused");
   AST_LOCK_RD: assert property (@(posedge sys_clk) disable iff (reset)
      seq_prg_locked_rd |-> seq_zero_answer)
      else $error("locked programmer read not zero");
   AST_CPU_RD: assert property (@(posedge sys_clk) disable iff (reset)
      cpu_rd_req |-> ##1 mem_re ##2 cpu_rd_valid)
      else $error("cpu read not served");
   AST_PART: assert property (@(posedge sys_clk) disable iff (reset)
      prg_rd_req && prg_go && prg_addr == PMG_PART_OFS
      |-> ##3 (prg_rd_valid && prg_rd_data == PART_CODE))
      else $error("part code read wrong");
   AST_BUS_REV: assert property (@(posedge sys_clk) disable iff (reset)
      bus_take && avs_read && avs_address == PMG_REV_OFS
      |-> avs_readdata == {18'h0, REV_CODE})
      else $error("revision word altered");
   AST_WIPE: assert property (@(posedge sys_clk) disable iff (reset)
      cfg_wipe |=> mem_erase_all && read_lock_n && guard == PMG_GUARD_RST)
      else $error("erase did not wipe all");

endmodule // pmg_guard
`default_nettype wire

/* pmg_pkg.sv */
package pmg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int PMG_DW = 14;
   localparam int PMG_PM_AW = 13;
   localparam int PMG_AW = 16;
   localparam int PMG_BUS_DW = 32;
   localparam int PMG_UID_NUM = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices (byte address is four times the index)
   localparam logic [15:0] PMG_UID_BASE = 16'h8000;
   localparam logic [15:0] PMG_REV_OFS = 16'h8005;
   localparam logic [15:0] PMG_PART_OFS = 16'h8006;
   localparam logic [15:0] PMG_CFG_OFS = 16'h8008;
   localparam logic [15:0] PMG_STAT_OFS = 16'h8009;
   localparam int PMG_CFG_SPACE_BIT = 15;

   ////////////////////////////////////////////////////////////////////////////
   // Fields
   localparam int PMG_CFG_GUARD_LSB = 0;
   localparam int PMG_CFG_LOCK_BIT = 2;
   localparam int PMG_STAT_SELF_BIT = 0;
   localparam int PMG_STAT_EXT_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset and blank values
   localparam logic [13:0] PMG_BLANK_WORD = 14'h3fff;
   localparam logic [1:0] PMG_GUARD_RST = 2'h3;
   localparam logic PMG_LOCK_N_RST = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Guard codes and protected limits (first writable word)
   localparam logic [1:0] PMG_GUARD_OFF = 2'h3;
   localparam logic [1:0] PMG_GUARD_BOOT = 2'h2;
   localparam logic [1:0] PMG_GUARD_HALF = 2'h1;
   localparam logic [1:0] PMG_GUARD_ALL = 2'h0;
   localparam logic [13:0] PMG_LIM_NONE = 14'h0000;
   localparam logic [13:0] PMG_LIM_BOOT = 14'h0200;
   localparam logic [13:0] PMG_LIM_HALF4 = 14'h0800;
   localparam logic [13:0] PMG_LIM_ALL4 = 14'h1000;
   localparam logic [13:0] PMG_LIM_HALF8 = 14'h1000;
   localparam logic [13:0] PMG_LIM_ALL8 = 14'h2000;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: cycles from a taken read to its valid data
   localparam int PMG_RD_LAT = 3;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } pmg_bus_state_type;

   function automatic logic [13:0] pmg_guard_limit(input logic big,
                                                    input logic [1:0] g);
      logic [13:0] lim;
      lim = PMG_LIM_NONE;
      case (g)
         PMG_GUARD_BOOT: lim = PMG_LIM_BOOT;
         PMG_GUARD_HALF: lim = big ? PMG_LIM_HALF8 : PMG_LIM_HALF4;
         PMG_GUARD_ALL:  lim = big ? PMG_LIM_ALL8 : PMG_LIM_ALL4;
         default:        lim = PMG_LIM_NONE;
      endcase
      return lim;
   endfunction

endpackage

/* pmg_region_check.sv */
`timescale 1ns/10ps
`default_nettype none
module pmg_region_check
   import pmg_pkg::*;
#(
   parameter int MEM_KW = 4
) (
   // Configuration
   input  wire logic [1:0]           guard,
   // Address under test
   input  wire logic [PMG_PM_AW-1:0] addr_in,
   // Result
   output logic [PMG_PM_AW-1:0]      addr_out,
   output logic                      blocked
);

   localparam logic BIG = (MEM_KW == 8);
   localparam logic [PMG_PM_AW-1:0] MASK = BIG ? 13'h1fff : 13'h0fff;

   logic [13:0] limit;

   // Small parts wrap the unused top address bit, as the array does
   assign addr_out = addr_in & MASK;
   assign limit = pmg_guard_limit(BIG, guard);
   assign blocked = ({1'b0, addr_out} < limit);

endmodule // pmg_region_check
`default_nettype wire

/* pmg_prog_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pmg_prog_model
   import pmg_pkg::*;
(
   // Clock
   input  wire logic              sys_clk,
   // Commands
   output logic                   prg_rd_req,
   output logic                   prg_wr_req,
   output logic                   prg_erase_req,
   output logic                   prg_bulk_req,
   output logic [PMG_AW-1:0]      prg_addr,
   output logic [PMG_DW-1:0]      prg_wdata,
   // Answers
   input  wire logic              prg_waitreq,
   input  wire logic [PMG_DW-1:0] prg_rd_data,
   input  wire logic              prg_rd_valid
);
   logic [PMG_DW-1:0] last_data;
   logic              got_data;
   logic              taken;

   initial begin
      {prg_rd_req, prg_wr_req, prg_erase_req, prg_bulk_req} = 4'h0;
      prg_addr = 16'h0000;
      prg_wdata = 14'h0000;
      last_data = 14'h0000;
      got_data = 1'b0;
      taken = 1'b0;
   end

   // Kind 0 read, 1 write, 2 row erase, 3 bulk erase; slow idles first
   task automatic issue(input logic [1:0] kind, input logic [15:0] a, input logic [13:0] d,
                        input int slow);
      int n;
      taken = 1'b0;
      got_data = 1'b0;
      repeat (slow) @(posedge sys_clk);
      @(posedge sys_clk);
      prg_rd_req <= (kind == 2'h0);
      prg_wr_req <= (kind == 2'h1);
      prg_erase_req <= (kind == 2'h2);
      prg_bulk_req <= (kind == 2'h3);
      prg_addr <= a;
      prg_wdata <= d;
      // Hold the command until the edge that sees the wait low
      for (n = 0; n < 20 && !taken; n++) begin
         @(posedge sys_clk);
         taken = (prg_waitreq === 1'b0);
      end
      {prg_rd_req, prg_wr_req, prg_erase_req, prg_bulk_req} <= 4'h0;
      // Released lines must not keep showing the old value
      prg_addr <= ~a;
      prg_wdata <= ~d;
      for (n = 0; n < 6; n++) begin
         @(negedge sys_clk);
         if (prg_rd_valid === 1'b1) begin
            got_data = 1'b1;
            last_data = prg_rd_data;
         end
      end
   endtask
endmodule // pmg_prog_model
`default_nettype wire

/* pmg_guard_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pmg_guard_tb_top;
   import pmg_pkg::*;
   localparam int MEM_KW = 4;
   localparam int TOP = MEM_KW * 1024;
   localparam logic [13:0] PART = 14'h0123; // Arbitrary value
   localparam logic [13:0] REV = 14'h0002;  // Arbitrary value
   logic        sys_clk, reset, avs_read, avs_write, avs_waitrequest;
   logic [15:0] avs_address, prg_addr;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        cpu_rd_req, cpu_wr_req, cpu_rd_valid, cpu_wr_blocked;
   logic [12:0] cpu_addr, mem_addr;
   logic [13:0] cpu_wdata, cpu_rd_data, prg_wdata, prg_rd_data, mem_wdata, mem_rdata;
   logic        prg_rd_req, prg_wr_req, prg_erase_req, prg_bulk_req, prg_waitreq;
   logic        prg_rd_valid, prg_refused, mem_we, mem_re, mem_erase_row, mem_erase_all;
   int          n_errors, num_checks, n_we, n_blk, n_ref, n_ea, n_er;

   pmg_guard #(.MEM_KW(MEM_KW), .PART_CODE(PART), .REV_CODE(REV)) dut (
      .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cpu_rd_req(cpu_rd_req), .cpu_wr_req(cpu_wr_req),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rd_data(cpu_rd_data),
      .cpu_rd_valid(cpu_rd_valid), .cpu_wr_blocked(cpu_wr_blocked), .prg_rd_req(prg_rd_req),
      .prg_wr_req(prg_wr_req), .prg_erase_req(prg_erase_req), .prg_bulk_req(prg_bulk_req),
      .prg_addr(prg_addr), .prg_wdata(prg_wdata), .prg_waitreq(prg_waitreq),
      .prg_rd_data(prg_rd_data), .prg_rd_valid(prg_rd_valid), .prg_refused(prg_refused),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
      .mem_erase_row(mem_erase_row), .mem_erase_all(mem_erase_all), .mem_rdata(mem_rdata));

   pmg_prog_model prog (
      .sys_clk(sys_clk), .prg_rd_req(prg_rd_req), .prg_wr_req(prg_wr_req),
      .prg_erase_req(prg_erase_req), .prg_bulk_req(prg_bulk_req), .prg_addr(prg_addr),
      .prg_wdata(prg_wdata), .prg_waitreq(prg_waitreq), .prg_rd_data(prg_rd_data),
      .prg_rd_valid(prg_rd_valid));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [13:0] pat(input logic [12:0] a);
      return {1'b0, a} ^ 14'h2a5a;
   endfunction

   // Array answers one cycle after a read, garbage otherwise
   always @(posedge sys_clk) begin
      mem_rdata <= (mem_re === 1'b1) ? pat(mem_addr) : ~mem_rdata;
      n_we <= n_we + (mem_we === 1'b1);
      n_blk <= n_blk + (cpu_wr_blocked === 1'b1);
      n_ref <= n_ref + (prg_refused === 1'b1);
      n_ea <= n_ea + (mem_erase_all === 1'b1);
      n_er <= n_er + (mem_erase_row === 1'b1);
   end

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   task automatic av(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int  n;
      logic ok;
      ok = 1'b0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      // Waitrequest and read data are judged at the rising edge that takes the access
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge sys_clk);
         ok = (avs_waitrequest === 1'b0);
         q = avs_readdata;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      chk({31'h0, ok}, 32'h1);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      av(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   task automatic cpu_op(input logic wr, input logic [12:0] a, input int exp_blk);
      int w0, b0, nv;
      w0 = n_we;
      b0 = n_blk;
      nv = 0;
      @(posedge sys_clk);
      cpu_wr_req <= wr;
      cpu_rd_req <= !wr;
      cpu_addr <= a;
      cpu_wdata <= ~pat(a);
      @(posedge sys_clk);
      {cpu_wr_req, cpu_rd_req} <= 2'h0;
      cpu_addr <= ~a;
      for (int n = 0; n < 4; n++) begin
         @(negedge sys_clk);
         if (cpu_rd_valid === 1'b1) begin
            nv++;
            chk({18'h0, cpu_rd_data}, {18'h0, pat(a)});
         end
      end
      chk(nv, wr ? 0 : 1);
      chk(n_blk - b0, wr ? exp_blk : 0);
      chk(n_we - w0, wr ? 1 - exp_blk : 0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_ids();
      rd_chk(PMG_CFG_OFS, 32'h7);
      rd_chk(16'h8003, 32'h3fff);
      rd_chk(PMG_REV_OFS, {18'h0, REV});
      rd_chk(PMG_PART_OFS, {18'h0, PART});
      rd_chk(16'h8004, 32'h0);
      av(1'b1, PMG_REV_OFS, 32'h0);
      av(1'b1, PMG_PART_OFS, 32'h0);
      prog.issue(2'h1, PMG_PART_OFS, 14'h0, 0);
      prog.issue(2'h2, PMG_REV_OFS, 14'h0, 0);
      rd_chk(PMG_REV_OFS, {18'h0, REV});
      rd_chk(PMG_PART_OFS, {18'h0, PART});
      av(1'b1, 16'h8002, 32'h1abc);
      rd_chk(16'h8002, 32'h1abc);
   endtask

   task automatic t_guard();
      int lim;
      for (int g = 0; g < 4; g++) begin
         av(1'b1, PMG_CFG_OFS, 32'h4 | g);
         lim = (g == 3) ? 0 : (g == 2) ? 'h200 : (g == 1) ? TOP / 2 : TOP;
         if (lim > 0) cpu_op(1'b1, 13'(lim - 1), 1);
         cpu_op(1'b1, (lim == TOP) ? 13'h0 : 13'(lim), (lim == TOP));
         cpu_op(1'b0, 13'h0, 0);
      end
   endtask

   task automatic t_lock();
      int r0, w0, e0;
      av(1'b1, PMG_CFG_OFS, 32'h3);
      cpu_op(1'b1, 13'h123, 0);
      cpu_op(1'b0, 13'h045, 0);
      prog.issue(2'h0, 16'h0045, 14'h0, 2);
      chk({prog.got_data, prog.last_data}, 32'h4000);
      r0 = n_ref;
      w0 = n_we;
      prog.issue(2'h1, 16'h0045, 14'h1111, 0);
      chk(n_ref - r0, 1);
      chk(n_we - w0, 0);
      prog.issue(2'h0, PMG_PART_OFS, 14'h0, 0);
      chk({prog.got_data, prog.last_data}, {18'h1, PART});
      prog.issue(2'h0, PMG_REV_OFS, 14'h0, 1);
      chk({prog.got_data, prog.last_data}, {18'h1, REV});
      e0 = n_ea;
      prog.issue(2'h2, 16'h0045, 14'h0, 0);
      chk(n_ea - e0, 1);
      rd_chk(PMG_CFG_OFS, 32'h7);
      // Both sticky flags were set by earlier refusals and survive the erase
      rd_chk(PMG_STAT_OFS, 32'h3);
      av(1'b1, PMG_STAT_OFS, 32'h3);
      rd_chk(PMG_STAT_OFS, 32'h0);
   endtask

   task automatic t_unlocked();
      int r0, w0, e0;
      prog.issue(2'h0, 16'h0045, 14'h0, 3);
      chk({prog.got_data, prog.last_data}, {18'h1, pat(13'h045)});
      r0 = n_ref;
      w0 = n_we;
      prog.issue(2'h1, 16'h0046, 14'h1111, 0);
      chk(n_ref - r0, 0);
      chk(n_we - w0, 1);
      e0 = n_er;
      prog.issue(2'h2, 16'h0046, 14'h0, 0);
      chk(n_er - e0, 1);
      av(1'b1, 16'h8001, 32'h0aaa);
      av(1'b1, PMG_CFG_OFS, 32'h1);
      e0 = n_ea;
      prog.issue(2'h3, 16'h0000, 14'h0, 0);
      chk(n_ea - e0, 1);
      rd_chk(16'h8001, 32'h3fff);
      rd_chk(PMG_CFG_OFS, 32'h7);
   endtask

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      {n_errors, num_checks, n_we, n_blk, n_ref, n_ea, n_er} = '0;
      {avs_read, avs_write, cpu_rd_req, cpu_wr_req} = 4'h0;
      avs_address = 16'h0;
      avs_writedata = 32'h0;
      cpu_addr = 13'h0;
      cpu_wdata = 14'h0;
      mem_rdata = 14'h0;
      reset = 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset_ids();
      t_guard();
      t_lock();
      t_unlocked();
      summarize();
   end

   // The whole sequence needs well under a thousand cycles
   initial begin
      #(20000 * 25);
      n_errors++;
      summarize();
   end
endmodule // pmg_guard_tb_top
`default_nettype wire
